/* File: lane_pcs_pkg.sv */
// Constants shared by the single-lane serial PCS and its testbench.
package lane_pcs_pkg;
  // Line coding and alignment.
  localparam int SYM_BITS = 10;
  localparam logic [9:0] COMMA_NEG = 10'h17c; // Comma sent from negative disparity.
  localparam logic [9:0] COMMA_POS = 10'h283; // Comma sent from positive disparity.
  localparam logic [7:0] COMMA_BYTE = 8'hbc;
  localparam logic [7:0] IDLE_BYTE = 8'hbc;

  // Synchronisation thresholds.
  localparam int SYNC_COMMAS = 127;
  localparam int GOOD_RUN = 255;
  localparam int ERR_LIMIT = 3;
  localparam logic [6:0] SYNC_COMMAS_LAST = 7'(SYNC_COMMAS - 1);
  localparam logic [7:0] GOOD_RUN_MAX = 8'(GOOD_RUN);
  localparam logic [1:0] ERR_LAST = 2'(ERR_LIMIT - 1);

  // Supported line rates in Mbps and the matching fabric word clocks in kHz.
  localparam int RATE_LOW_MBPS = 1250;
  localparam int RATE_MID_MBPS = 2500;
  localparam int RATE_HIGH_MBPS = 3125;
  localparam int WCLK_LOW_KHZ = 62500;
  localparam int WCLK_MID_KHZ = 125000;
  localparam int WCLK_HIGH_KHZ = 156250;
  localparam int BYTES_PER_WORD = 2;

  // Receive synchronisation states.
  typedef enum logic {SYNC_LOST, SYNC_HELD} sync_state_t;
endpackage : lane_pcs_pkg

/* File: codec_if.sv */
// Carrier between the lane PCS and its 8b/10b codec.
`timescale 1ns/10ps
interface codec_if;
  logic enc_k;
  logic [7:0] enc_data;
  logic enc_rd_in;
  logic [9:0] enc_code;
  logic enc_rd_out;
  logic [9:0] dec_code;
  logic dec_rd_in;
  logic [7:0] dec_data;
  logic dec_k;
  logic dec_valid;
  logic dec_rd_out;
  modport user (output enc_k, enc_data, enc_rd_in, dec_code, dec_rd_in,
                input enc_code, enc_rd_out, dec_data, dec_k, dec_valid, dec_rd_out);
  modport codec (input enc_k, enc_data, enc_rd_in, dec_code, dec_rd_in,
                 output enc_code, enc_rd_out, dec_data, dec_k, dec_valid, dec_rd_out);
endinterface : codec_if

/* File: codec_8b10b.sv */
// Combinational 8b/10b encoder and table-checked decoder.
`timescale 1ns/10ps
module codec_8b10b (
  codec_if.codec cif
);
  localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
    6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  // Legal control characters: K28.x and K23/27/29/30.7.
  function automatic logic k_ok(input logic [7:0] d);
    k_ok = (d[4:0] == 5'h1c) ||
           (d[7:5] == 3'h7 && (d[4:0] == 5'h17 || d[4:0] == 5'h1b ||
                               d[4:0] == 5'h1d || d[4:0] == 5'h1e));
  endfunction : k_ok

  // Returns {ending disparity, code}; code bit 0 is the first bit on the line.
  function automatic logic [10:0] enc(input logic k, input logic [7:0] d, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic rdm;
    logic [9:0] sym;
    logic [9:0] code;
    s6 = (k && d[4:0] == 5'h1c) ? 6'h0f : T6[d[4:0]];
    if (rd && ($countones(s6) != 3 || s6 == 6'h38)) begin
      s6 = ~s6;
    end
    rdm = ($countones(s6) == 3) ? rd : ~rd;
    s4 = T4[d[7:5]];
    if (d[7:5] == 3'h7 && (k || (!rdm && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
        d[4:0] == 5'h14)) || (rdm && (d[4:0] == 5'h0b || d[4:0] == 5'h0d ||
        d[4:0] == 5'h0e)))) begin
      s4 = 4'h7;
    end
    if (k && $countones(s4) == 2 && d[7:5] != 3'h3) begin
      if (!rdm) begin
        s4 = ~s4;
      end
    end else if (rdm && ($countones(s4) != 2 || d[7:5] == 3'h3)) begin
      s4 = ~s4;
    end
    sym = {s6, s4};
    for (int i = 0; i < 10; i++) begin
      code[i] = sym[9 - i];
    end
    enc = {(($countones(s4) == 2) ? rdm : ~rdm), code};
  endfunction : enc

  // Encoder path.
  always_comb begin
    logic [10:0] r;
    r = enc(cif.enc_k, cif.enc_data, cif.enc_rd_in);
    cif.enc_code = r[9:0];
    cif.enc_rd_out = r[10];
  end

  // Decoder: a group is valid only if some legal character encodes to it from this disparity.
  always_comb begin
    logic [10:0] r;
    logic [8:0] cand;
    r = 11'h000;
    cand = 9'h000;
    cif.dec_valid = 1'b0;
    cif.dec_data = 8'h00;
    cif.dec_k = 1'b0;
    cif.dec_rd_out = cif.dec_rd_in;
    for (int c = 0; c < 512; c++) begin
      cand = 9'(c);
      r = enc(cand[8], cand[7:0], cif.dec_rd_in);
      if (r[9:0] == cif.dec_code && (!cand[8] || k_ok(cand[7:0]))) begin
        cif.dec_valid = 1'b1;
        cif.dec_data = cand[7:0];
        cif.dec_k = cand[8];
        cif.dec_rd_out = r[10];
      end
    end
  end
endmodule : codec_8b10b

/* File: serial_lane_pcs.sv */
// Single-lane serial PCS: coding, comma alignment, lane sync and byte (de)serialisation.
`timescale 1ns/10ps
module serial_lane_pcs #(
  parameter int LINE_RATE_MBPS = lane_pcs_pkg::RATE_HIGH_MBPS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] tx_word,
  input wire logic [1:0] tx_kflag,
  output logic tx_word_ready,
  output logic tx_bit,
  input wire logic rx_bit,
  output logic [15:0] rx_word,
  output logic [1:0] rx_kflag,
  output logic [1:0] rx_code_err,
  output logic rx_word_valid,
  output logic lane_sync
);
  // Fabric word clock for the chosen rate; only single-lane rates are legal.
  localparam int WORD_CLK_KHZ =
    (LINE_RATE_MBPS == lane_pcs_pkg::RATE_LOW_MBPS) ? lane_pcs_pkg::WCLK_LOW_KHZ :
    (LINE_RATE_MBPS == lane_pcs_pkg::RATE_MID_MBPS) ? lane_pcs_pkg::WCLK_MID_KHZ :
    lane_pcs_pkg::WCLK_HIGH_KHZ;
  localparam logic [3:0] BIT_LAST = 4'(lane_pcs_pkg::SYM_BITS - 1);

  codec_if cif ();

  codec_8b10b u_codec (
    .cif(cif)
  );

  // Transmit state.
  logic [9:0] tx_sr_reg, tx_sr_next;
  logic [3:0] tx_cnt_reg, tx_cnt_next;
  logic tx_phase_reg, tx_phase_next;
  logic tx_rd_reg, tx_rd_next;
  logic [7:0] tx_hold_reg, tx_hold_next;
  logic tx_hold_k_reg, tx_hold_k_next;
  logic tx_load;

  // Receive state.
  logic [9:0] rx_sr_reg, rx_sr_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic rx_rd_reg, rx_rd_next;
  logic rx_phase_reg, rx_phase_next;
  logic [7:0] rx_lo_reg, rx_lo_next;
  logic rx_lo_k_reg, rx_lo_k_next;
  logic rx_lo_err_reg, rx_lo_err_next;
  logic [15:0] rx_word_reg, rx_word_next;
  logic [1:0] rx_kflag_reg, rx_kflag_next;
  logic [1:0] rx_err_reg, rx_err_next;
  logic rx_valid_reg, rx_valid_next;
  logic comma_hit, realign, sym_strobe, sym_bad, sym_comma;

  // Synchronisation state.
  lane_pcs_pkg::sync_state_t sync_reg, sync_next;
  logic [6:0] comma_cnt_reg, comma_cnt_next;
  logic [1:0] err_cnt_reg, err_cnt_next;
  logic [7:0] good_cnt_reg, good_cnt_next;

  // Transmit: a new code group every ten bits; one fabric word per two groups.
  assign tx_load = (tx_cnt_reg == BIT_LAST);
  assign tx_word_ready = tx_load && !tx_phase_reg;
  assign cif.enc_k = tx_phase_reg ? tx_hold_k_reg : tx_kflag[0];
  assign cif.enc_data = tx_phase_reg ? tx_hold_reg : tx_word[7:0];
  assign cif.enc_rd_in = tx_rd_reg;
  assign tx_bit = tx_sr_reg[0];

  always_comb begin
    tx_sr_next = {1'b0, tx_sr_reg[9:1]};
    tx_cnt_next = tx_load ? 4'h0 : tx_cnt_reg + 4'h1;
    tx_phase_next = tx_phase_reg;
    tx_rd_next = tx_rd_reg;
    tx_hold_next = tx_hold_reg;
    tx_hold_k_next = tx_hold_k_reg;
    if (tx_load) begin
      tx_sr_next = cif.enc_code;
      tx_rd_next = cif.enc_rd_out;
      tx_phase_next = !tx_phase_reg;
      if (!tx_phase_reg) begin
        tx_hold_next = tx_word[15:8];
        tx_hold_k_next = tx_kflag[1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_sr_reg <= 10'h000;
      tx_cnt_reg <= 4'h0;
      tx_phase_reg <= 1'b0;
      tx_rd_reg <= 1'b0;
      tx_hold_reg <= 8'h00;
      tx_hold_k_reg <= 1'b0;
    end else begin
      tx_sr_reg <= tx_sr_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_phase_reg <= tx_phase_next;
      tx_rd_reg <= tx_rd_next;
      tx_hold_reg <= tx_hold_next;
      tx_hold_k_reg <= tx_hold_k_next;
    end
  end

  // Receive alignment: the line bit is already timed by the recovered clock.
  assign comma_hit = (rx_sr_reg == lane_pcs_pkg::COMMA_NEG) ||
                     (rx_sr_reg == lane_pcs_pkg::COMMA_POS);
  assign realign = comma_hit && (sync_reg == lane_pcs_pkg::SYNC_LOST);
  assign sym_strobe = realign || (rx_cnt_reg == BIT_LAST);
  assign cif.dec_code = rx_sr_reg;
  assign cif.dec_rd_in = realign ? (rx_sr_reg == lane_pcs_pkg::COMMA_POS) : rx_rd_reg;
  assign sym_bad = !cif.dec_valid;
  assign sym_comma = cif.dec_valid && cif.dec_k && (cif.dec_data == lane_pcs_pkg::COMMA_BYTE);

  // Receive data path: pairs decoded bytes into words, low byte first.
  always_comb begin
    rx_sr_next = {rx_bit, rx_sr_reg[9:1]};
    rx_cnt_next = sym_strobe ? 4'h0 : rx_cnt_reg + 4'h1;
    rx_rd_next = (sym_strobe && cif.dec_valid) ? cif.dec_rd_out : rx_rd_reg;
    rx_phase_next = rx_phase_reg;
    rx_lo_next = rx_lo_reg;
    rx_lo_k_next = rx_lo_k_reg;
    rx_lo_err_next = rx_lo_err_reg;
    rx_word_next = rx_word_reg;
    rx_kflag_next = rx_kflag_reg;
    rx_err_next = rx_err_reg;
    rx_valid_next = 1'b0;
    if (sync_reg == lane_pcs_pkg::SYNC_LOST) begin
      rx_phase_next = 1'b0;
    end else if (sym_strobe) begin
      rx_phase_next = !rx_phase_reg;
      if (!rx_phase_reg) begin
        rx_lo_next = cif.dec_data;
        rx_lo_k_next = cif.dec_k;
        rx_lo_err_next = sym_bad;
      end else begin
        rx_word_next = {cif.dec_data, rx_lo_reg};
        rx_kflag_next = {cif.dec_k, rx_lo_k_reg};
        rx_err_next = {sym_bad, rx_lo_err_reg};
        rx_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_sr_reg <= 10'h000;
      rx_cnt_reg <= 4'h0;
      rx_rd_reg <= 1'b0;
      rx_phase_reg <= 1'b0;
      rx_lo_reg <= 8'h00;
      rx_lo_k_reg <= 1'b0;
      rx_lo_err_reg <= 1'b0;
      rx_word_reg <= 16'h0000;
      rx_kflag_reg <= 2'h0;
      rx_err_reg <= 2'h0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_sr_reg <= rx_sr_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_rd_reg <= rx_rd_next;
      rx_phase_reg <= rx_phase_next;
      rx_lo_reg <= rx_lo_next;
      rx_lo_k_reg <= rx_lo_k_next;
      rx_lo_err_reg <= rx_lo_err_next;
      rx_word_reg <= rx_word_next;
      rx_kflag_reg <= rx_kflag_next;
      rx_err_reg <= rx_err_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

  // Lane sync machine; it looks only at this lane, so bundled lanes never deskew.
  always_comb begin
    sync_next = sync_reg;
    comma_cnt_next = comma_cnt_reg;
    err_cnt_next = err_cnt_reg;
    good_cnt_next = good_cnt_reg;
    case (sync_reg)
      lane_pcs_pkg::SYNC_LOST: begin
        if (sym_strobe) begin
          if (sym_bad) begin
            comma_cnt_next = 7'h00;
          end else if (sym_comma) begin
            comma_cnt_next = comma_cnt_reg + 7'h01;
            if (comma_cnt_reg == lane_pcs_pkg::SYNC_COMMAS_LAST) begin
              sync_next = lane_pcs_pkg::SYNC_HELD;
              comma_cnt_next = 7'h00;
              err_cnt_next = 2'h0;
              good_cnt_next = 8'h00;
            end
          end
        end
      end
      lane_pcs_pkg::SYNC_HELD: begin
        if (sym_strobe) begin
          if (sym_bad) begin
            good_cnt_next = 8'h00;
            if (good_cnt_reg == lane_pcs_pkg::GOOD_RUN_MAX) begin
              err_cnt_next = 2'h1;
            end else if (err_cnt_reg == lane_pcs_pkg::ERR_LAST) begin
              sync_next = lane_pcs_pkg::SYNC_LOST;
              err_cnt_next = 2'h0;
            end else begin
              err_cnt_next = err_cnt_reg + 2'h1;
            end
          end else if (good_cnt_reg != lane_pcs_pkg::GOOD_RUN_MAX) begin
            good_cnt_next = good_cnt_reg + 8'h01;
          end
        end
      end
      default: begin
        sync_next = lane_pcs_pkg::SYNC_LOST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_reg <= lane_pcs_pkg::SYNC_LOST;
      comma_cnt_reg <= 7'h00;
      err_cnt_reg <= 2'h0;
      good_cnt_reg <= 8'h00;
    end else begin
      sync_reg <= sync_next;
      comma_cnt_reg <= comma_cnt_next;
      err_cnt_reg <= err_cnt_next;
      good_cnt_reg <= good_cnt_next;
    end
  end

  assign lane_sync = (sync_reg == lane_pcs_pkg::SYNC_HELD);
  assign rx_word = rx_word_reg;
  assign rx_kflag = rx_kflag_reg;
  assign rx_code_err = rx_err_reg;
  assign rx_word_valid = rx_valid_reg;

  // Checks on the sync machine, aligner and serialisers.
  a_rate_word_clock: assert property (@(posedge clk)
    WORD_CLK_KHZ * lane_pcs_pkg::BYTES_PER_WORD * lane_pcs_pkg::SYM_BITS ==
    LINE_RATE_MBPS * 1000)
    else $error("Word clock does not match the line rate.");
  a_sync_after_commas: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(lane_sync) |-> $past(comma_cnt_reg) == 7'h7e && $past(sym_comma))
    else $error("Sync raised without 127 commas.");
  a_bad_clears_count: assert property (@(posedge clk) disable iff (sys_rst)
    !lane_sync && sym_strobe && sym_bad |=> comma_cnt_reg == 7'h00 && !lane_sync)
    else $error("Invalid group did not restart the comma count.");
  a_comma_sets_boundary: assert property (@(posedge clk) disable iff (sys_rst)
    realign |=> rx_cnt_reg == 4'h0 ##9 rx_cnt_reg == 4'h9)
    else $error("Comma did not set the symbol boundary.");
  a_third_error_drops: assert property (@(posedge clk) disable iff (sys_rst)
    lane_sync && sym_strobe && sym_bad && err_cnt_reg == 2'h2 && good_cnt_reg < 8'hff
    |=> !lane_sync)
    else $error("Third close invalid group kept sync.");
  a_spaced_error_holds: assert property (@(posedge clk) disable iff (sys_rst)
    lane_sync && sym_strobe && sym_bad && good_cnt_reg == 8'hff |=> lane_sync[*2])
    else $error("Widely spaced invalid group dropped sync.");
  a_reset_drops_sync: assert property (@(posedge clk)
    sys_rst |=> !lane_sync && comma_cnt_reg == 7'h00)
    else $error("Reset did not force loss of sync.");
  a_tx_word_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    tx_word_ready |=> !tx_word_ready[*8] ##1 !tx_word_ready[*8] ##1 !tx_word_ready[*3]
    ##1 tx_word_ready)
    else $error("Transmit words not one per twenty bits.");
  a_rx_word_spacing: assert property (@(posedge clk) disable iff (sys_rst)
    rx_word_valid |=> !rx_word_valid[*8])
    else $error("Receive words closer than two groups.");
  a_tx_code_legal: assert property (@(posedge clk) disable iff (sys_rst)
    tx_load |-> $countones(cif.enc_code) >= 4 && $countones(cif.enc_code) <= 6)
    else $error("Transmitted group has illegal disparity.");
  a_bad_not_counted: assert property (@(posedge clk) disable iff (sys_rst)
    lane_sync && sym_strobe && sym_bad |=> good_cnt_reg == 8'h00)
    else $error("Invalid group counted as valid.");

  c_sync_reached: cover property (@(posedge clk) disable iff (sys_rst) $rose(lane_sync));
  c_sync_lost: cover property (@(posedge clk) disable iff (sys_rst) $fell(lane_sync));
  c_rx_ctrl_word: cover property (@(posedge clk) disable iff (sys_rst)
    rx_word_valid && rx_kflag != 2'h0);
  c_tx_word: cover property (@(posedge clk) disable iff (sys_rst) tx_word_ready);
endmodule : serial_lane_pcs

/* File: lane_partner.sv */
// Remote lane partner that sends comma, data and invalid code groups on the serial line.
`timescale 1ns/10ps
module lane_partner (
  input wire logic clk,
  output logic line
);
  int q[$];
  int bitn;
  int kind;
  logic rd_pos;
  logic [9:0] cur;

  // Queue one group: 0 is a data filler, 1 a comma, 2 an invalid group.
  task push(input int k);
    q.push_back(k);
  endtask : push

  // Pick the group form; the comma flips the running disparity, the filler keeps it.
  function automatic logic [9:0] form(input int k);
    logic [9:0] c;
    c = 10'h155; // Neutral data group, also the idle filler the far side makes.
    if (k == 1) begin
      c = rd_pos ? 10'h283 : 10'h17c; // Both comma forms in turn.
      rd_pos = ~rd_pos;
    end else if (k == 2) begin
      c = 10'h000; // Absent from the code table.
    end
    return c;
  endfunction : form

  // Start idle on a group boundary with negative disparity.
  initial begin
    line = 1'b0;
    rd_pos = 1'b0;
    bitn = 0;
    cur = 10'h155;
  end

  // Shift one bit per clock, bit a first; sharing the clock keeps the offset at zero.
  always @(posedge clk) begin
    #2;
    if (bitn == 0) begin
      kind = 0;
      if (q.size() > 0) begin
        kind = q.pop_front();
      end
      cur = form(kind);
    end
    line = cur[bitn];
    bitn = (bitn == 9) ? 0 : bitn + 1;
  end
endmodule : lane_partner

/* File: serial_rapidio_lane_pcs_test.sv */
// Self-checking bench for the single-lane serial PCS.
`timescale 1ns/10ps
module serial_rapidio_lane_pcs_test;
  logic clk;
  logic sys_rst;
  logic [15:0] tx_word;
  logic [1:0] tx_kflag;
  logic tx_word_ready;
  logic tx_bit;
  logic rx_bit;
  logic [15:0] rx_word;
  logic [1:0] rx_kflag;
  logic [1:0] rx_code_err;
  logic rx_word_valid;
  logic lane_sync;
  int fails;
  int compares;
  int err_words;
  logic [39:0] tx_cap;

  // The low rate only picks an internal word clock constant; the ports behave alike.
  serial_lane_pcs #(.LINE_RATE_MBPS(lane_pcs_pkg::RATE_LOW_MBPS)) dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .tx_word(tx_word),
    .tx_kflag(tx_kflag),
    .tx_word_ready(tx_word_ready),
    .tx_bit(tx_bit),
    .rx_bit(rx_bit),
    .rx_word(rx_word),
    .rx_kflag(rx_kflag),
    .rx_code_err(rx_code_err),
    .rx_word_valid(rx_word_valid),
    .lane_sync(lane_sync)
  );

  lane_partner far (
    .clk(clk),
    .line(rx_bit)
  );

  always #25 clk = ~clk;

  // Count received words that flag a bad code group.
  always @(posedge clk) begin
    if (rx_word_valid === 1'b1 && rx_code_err !== 2'b00) begin
      err_words++;
    end
  end

  // Compare a seen value with the expected one.
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Wait for edges, then step off the edge so drives never race it.
  task cycles(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cycles

  task feed(input int kind, input int n);
    repeat (n) far.push(kind);
  endtask : feed

  // Let the queued groups leave the partner and settle at the receiver.
  task drain;
    int i;
    i = 0;
    while (far.q.size() > 0 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    cycles(13);
  endtask : drain

  // Two words out: comma then filler, twice, with disparity carried across.
  task test_tx;
    int i;
    i = 0;
    while (tx_word_ready !== 1'b1 && i < 40) begin
      @(negedge clk);
      i++;
    end
    @(posedge clk);
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      tx_cap[i] = tx_bit;
      if (i == 18) check(tx_word_ready, 1'b0);
      if (i == 19) check(tx_word_ready, 1'b1);
    end
    check(tx_cap[9:0] == 10'h17c || tx_cap[9:0] == 10'h283, 1'b1);
    check(tx_cap[19:10], 10'h155);
    check(tx_cap[29:20], tx_cap[9:0] ^ 10'h3ff);
    check(tx_cap[39:30], 10'h155);
    cycles(1);
    $display("test_tx done");
  endtask : test_tx

  // Acquire sync; an invalid group mid-run restarts the comma count.
  task test_acquire;
    feed(1, 60);
    feed(2, 1);
    feed(1, 126);
    drain();
    check(lane_sync, 1'b0);
    feed(1, 1);
    feed(0, 1);
    feed(1, 1);
    drain();
    check(lane_sync, 1'b1);
    check(rx_word, 16'hbcb5);
    check(rx_kflag, 2'b10);
    check(rx_code_err, 2'b00);
    $display("test_acquire done");
  endtask : test_acquire

  // Reset in mid-run throws a synced lane back to loss of sync.
  task test_reset;
    feed(1, 127);
    drain();
    check(lane_sync, 1'b1);
    sys_rst = 1'b1;
    cycles(3);
    check(lane_sync, 1'b0);
    check(tx_bit, 1'b0);
    check(rx_word_valid, 1'b0);
    check(rx_word, 16'h0000);
    sys_rst = 1'b0;
    cycles(25);
    check(lane_sync, 1'b0);
    $display("test_reset done");
  endtask : test_reset

  // A run of 255 valid groups forgives earlier errors; three close ones drop sync.
  task test_loss;
    err_words = 0;
    feed(1, 127);
    feed(2, 1);
    feed(0, 255);
    feed(2, 1);
    feed(0, 3);
    feed(2, 1);
    drain();
    check(lane_sync, 1'b1);
    feed(0, 3);
    feed(2, 1);
    drain();
    check(lane_sync, 1'b0);
    check(err_words != 0, 1'b1);
    $display("test_loss done");
  endtask : test_loss

  // Print the counts and the verdict, then stop.
  task end_sim;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // Main sequence; the fabric holds one word that is taken at every ready pulse.
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    tx_word = 16'hb5bc;
    tx_kflag = 2'b01;
    fails = 0;
    compares = 0;
    err_words = 0;
    cycles(20);
    check(lane_sync, 1'b0);
    sys_rst = 1'b0;
    test_tx();
    test_acquire();
    test_reset();
    test_loss();
    end_sim();
  end

  // Cut a hang short well past the expected run of about seven thousand cycles.
  initial begin
    #(50 * 40000);
    fails++;
    end_sim();
  end
endmodule : serial_rapidio_lane_pcs_test
